// >>> baud_gen_params.svh
`ifndef BAUD_GEN_PARAMS_SVH
`define BAUD_GEN_PARAMS_SVH

// Register byte addresses on the Avalon-MM slave.
`define ADDR_BAUD_DIVISOR_HIGH 4'h0
`define ADDR_BAUD_DIVISOR_LOW  4'h1
`define ADDR_SERIAL_CTRL_TWO   4'h2
`define ADDR_EVENT_STATUS      4'h3
`define ADDR_EVENT_MASK        4'h4
`define ADDR_LINE_CONFIG       4'h5

// Field positions.
`define BIT_LINE_BREAK_IRQ_EN 7
`define BIT_RX_EDGE_IRQ_EN    6
`define BIT_TX_UNIT_ON        3
`define BIT_RX_UNIT_ON        2
`define BIT_SEND_BREAK        0
`define BIT_NINE_BIT          0
`define BIT_LONG_BREAK        1
`define EVT_LINE_BREAK        0
`define EVT_RX_EDGE           1

// Reset values.
`define RST_DIV_HIGH 8'h00
`define RST_DIV_LOW  8'h04

// Divisor and oversampling figures.
`define DIV_WIDTH  13
`define OVERSAMPLE 16
`define TX_BRK_LONG  13
`define RX_BRK_LONG  11

`endif

// >>> baud_gen_pkg.sv
`default_nettype none
package baud_gen_pkg;
  typedef logic [12:0] divisor_t;
  typedef enum logic [0:0] {gen_idle, gen_run} gen_state_t;
endpackage
`default_nettype wire

// >>> baud_tick_if.sv
`default_nettype none
interface baud_tick_if;
  logic        run;
  logic [12:0] divisor;
  logic        tick;
  modport ctrl (output run, output divisor, input tick);
  modport gen (input run, input divisor, output tick);
endinterface
`default_nettype wire

// >>> baud_counter.sv
`include "baud_gen_params.svh"
`default_nettype none
module baud_counter
  import baud_gen_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  baud_tick_if.gen  bus
);
  typedef struct packed {
    divisor_t   cnt;
    logic       tick;
    gen_state_t st;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  // Down counter reloads from the divisor and emits one tick per reload.
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    unique case (s_q.st)
      gen_idle:
      begin
        s_d.cnt = bus.divisor;
        if (bus.run && bus.divisor != '0)
          s_d.st = gen_run;
      end
      gen_run:
      begin
        if (!bus.run || bus.divisor == '0)
        begin
          s_d.st = gen_idle;
        end
        else if (s_q.cnt <= 13'h0001)
        begin
          s_d.cnt = bus.divisor;
          s_d.tick = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt - 13'h0001;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      s_q <= '{cnt: '0, tick: 1'b0, st: gen_idle};
    else
      s_q <= s_d;
  end

  assign bus.tick = s_q.tick;
endmodule // baud_counter
`default_nettype wire

// >>> serial_baud_rate_generator.sv
// Behaviour
// - High divisor write only buffers; low write loads both halves together.
// - Divisor is 13 bits: high register bits 4:0, low register bits 7:0.
// - Low byte resets nonzero; generator stays stopped until rx or tx enabled.
// - Zero divisor halts the generator completely.
// - Bit rate equals bus clock over sixteen times divisor.
// - High bit 7 enables interrupt from the line break flag.
// - High bit 6 enables interrupt from the receive edge flag.
// - Optional 13-bit break transmit, 11-bit break detect length indication.
// - Character length selectable 8 or 9 bits; both ends must match.
//
// The register offsets and register access over Avalon-MM were decided locally.
`include "baud_gen_params.svh"
`default_nettype none
module serial_baud_rate_generator
  import baud_gen_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] avs_address_in,
  input  wire logic       avs_read_in,
  input  wire logic       avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0] avs_byteenable_in,
  output logic [31:0]     avs_readdata_out,
  output logic            avs_waitrequest_out,
  input  wire logic       line_break_event_in,
  input  wire logic       rx_edge_event_in,
  output logic            irq_out,
  output logic            oversample_tick_out,
  output logic            rx_unit_on_out,
  output logic            tx_unit_on_out,
  output logic            nine_bit_out,
  output logic            send_break_out,
  output logic [3:0]      tx_break_bits_out,
  output logic [3:0]      rx_break_bits_out
);
  import baud_gen_pkg::*;

  typedef struct packed {
    logic [7:0]  div_high_buf;
    divisor_t    divisor;
    logic [1:0]  irq_en;
    logic        rx_on;
    logic        tx_on;
    logic        send_brk;
    logic        nine_bit;
    logic        long_brk;
    logic        started;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        irq;
    logic        tick;
    logic        ack;
    logic        wait_req;
    logic [3:0]  tx_brk_bits;
    logic [3:0]  rx_brk_bits;
    logic [31:0] rdata;
    logic [1:0]  ev_s1;
    logic [1:0]  ev_s2;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  baud_tick_if gen_bus();

  // Decodes a register address into the byte presented on read.
  function automatic logic [7:0] reg_byte(input top_state_t s, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `ADDR_BAUD_DIVISOR_HIGH: v = {s.irq_en, 1'b0, s.div_high_buf[4:0]};
      `ADDR_BAUD_DIVISOR_LOW:  v = s.divisor[7:0];
      `ADDR_SERIAL_CTRL_TWO:   v = {4'h0, s.tx_on, s.rx_on, 1'b0, s.send_brk};
      `ADDR_EVENT_STATUS:      v = {6'h00, s.status};
      `ADDR_EVENT_MASK:        v = {6'h00, s.mask};
      `ADDR_LINE_CONFIG:       v = {6'h00, s.long_brk, s.nine_bit};
      default:                 v = 8'h00;
    endcase
    return v;
  endfunction

  // Register access, event capture and interrupt combination.
  always_comb
  begin
    logic       wr;
    logic [7:0] wb;
    logic [1:0] ev;
    s_d = s_q;
    // A write lands only on the edge at which the master sees waitrequest low.
    wr = avs_write_in && s_q.ack && avs_byteenable_in[0];
    wb = avs_writedata_in[7:0];
    s_d.ev_s1 = {rx_edge_event_in, line_break_event_in};
    s_d.ev_s2 = s_q.ev_s1;
    ev = s_q.ev_s2;
    // One wait cycle, then acknowledge each access.
    s_d.ack = (avs_read_in || avs_write_in) && !s_q.ack;
    s_d.wait_req = !s_d.ack;
    s_d.rdata = {24'h000000, reg_byte(s_q, avs_address_in)};
    if (wr)
    begin
      unique case (avs_address_in)
        `ADDR_BAUD_DIVISOR_HIGH:
        begin
          s_d.div_high_buf = {3'b000, wb[4:0]};
          s_d.irq_en = wb[7:6];
        end
        `ADDR_BAUD_DIVISOR_LOW:
          s_d.divisor = {s_q.div_high_buf[4:0], wb};
        `ADDR_SERIAL_CTRL_TWO:
        begin
          s_d.tx_on = wb[`BIT_TX_UNIT_ON];
          s_d.rx_on = wb[`BIT_RX_UNIT_ON];
          s_d.send_brk = wb[`BIT_SEND_BREAK];
          if (wb[`BIT_TX_UNIT_ON] || wb[`BIT_RX_UNIT_ON])
            s_d.started = 1'b1;
        end
        `ADDR_EVENT_MASK:
          s_d.mask = wb[1:0];
        `ADDR_LINE_CONFIG:
        begin
          s_d.nine_bit = wb[`BIT_NINE_BIT];
          s_d.long_brk = wb[`BIT_LONG_BREAK];
        end
        default:
          s_d.ack = s_d.ack;
      endcase
    end
    // Write one to clear; a new event in the same cycle wins.
    if (wr && avs_address_in == `ADDR_EVENT_STATUS)
      s_d.status = s_q.status & ~wb[1:0];
    s_d.status = s_d.status | ev;
    // Status bits gated by mask and by the per-flag enables.
    s_d.irq = |(s_d.status & s_d.mask & {s_d.irq_en[0], s_d.irq_en[1]});
    s_d.tick = gen_bus.tick;
    // Break lengths: long break option lengthens both transmit (13) and detect (11), else 10.
    s_d.tx_brk_bits = s_d.long_brk ? 4'(`TX_BRK_LONG) : 4'ha;
    s_d.rx_brk_bits = s_d.long_brk ? 4'(`RX_BRK_LONG) : 4'ha;
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= '0;
      s_q.div_high_buf <= `RST_DIV_HIGH;
      s_q.divisor <= {5'h00, `RST_DIV_LOW};
      s_q.wait_req <= 1'b1;
      s_q.tx_brk_bits <= 4'ha;
      s_q.rx_brk_bits <= 4'ha;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Generator runs only after a unit is enabled and while one is on.
  assign gen_bus.run = s_q.started && (s_q.rx_on || s_q.tx_on);
  assign gen_bus.divisor = s_q.divisor;

  baud_counter u_counter (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .bus        (gen_bus)
  );

  // Outputs straight from the state register.
  assign avs_readdata_out = s_q.rdata;
  assign avs_waitrequest_out = s_q.wait_req;
  assign irq_out = s_q.irq;
  assign oversample_tick_out = s_q.tick;
  assign rx_unit_on_out = s_q.rx_on;
  assign tx_unit_on_out = s_q.tx_on;
  assign nine_bit_out = s_q.nine_bit;
  assign send_break_out = s_q.send_brk;
  assign tx_break_bits_out = s_q.tx_brk_bits;
  assign rx_break_bits_out = s_q.rx_brk_bits;
endmodule // serial_baud_rate_generator
`default_nettype wire

// >>> baud_gen_asserts.sv
`default_nettype none
module baud_gen_asserts (
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        irq_out,
  input wire logic        oversample_tick_out,
  input wire logic        rx_unit_on_out,
  input wire logic        tx_unit_on_out,
  input wire logic [3:0]  tx_break_bits_out,
  input wire logic [3:0]  rx_break_bits_out
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  property p_ack; s_req |=> !avs_waitrequest_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_hi; avs_readdata_out[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("read bits");
  property p_unm; avs_read_in && !avs_waitrequest_out && avs_address_in > 4'h5
    |-> avs_readdata_out == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_off; (!rx_unit_on_out && !tx_unit_on_out) [*4]
    |-> !oversample_tick_out; endproperty
  a_off: assert property (p_off) else $error("tick while off");
  property p_brk; tx_break_bits_out == (rx_break_bits_out == 4'hb ? 4'hd : 4'ha); endproperty
  a_brk: assert property (p_brk) else $error("break length");
  property p_irq; $fell(irq_out) |-> $past(avs_write_in) || $past(avs_write_in, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq drop");
  property p_on; $changed({rx_unit_on_out, tx_unit_on_out, tx_break_bits_out})
    |-> $past(avs_write_in); endproperty
  a_on: assert property (p_on) else $error("config moved");
endmodule // baud_gen_asserts
bind serial_baud_rate_generator baud_gen_asserts chk (.*);
`default_nettype wire

// >>> line_partner.sv
`default_nettype none
module line_partner (
  input  wire logic ref_clk_in,
  input  wire logic tick_in,
  input  wire logic go_in,
  output logic      edge_out,
  output logic      brk_out
);
  logic [7:0] n_q;
  // Counts oversampling ticks while the far end holds the line low.
  always_ff @(posedge ref_clk_in)
  begin
    if (!go_in) n_q <= 8'h00;
    else if (tick_in && n_q != 8'hff) n_q <= n_q + 8'h01;
  end
  // The start edge shows after one bit time of sixteen ticks.
  assign edge_out = go_in && n_q >= 8'h10;
  assign brk_out = go_in && n_q >= 8'hb0;
endmodule // line_partner
`default_nettype wire

// >>> serial_baud_rate_generator_tb.sv
`default_nettype none
module serial_baud_rate_generator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import baud_gen_pkg::*;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, go = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic avs_waitrequest_out, irq_out, oversample_tick_out, rx_unit_on_out, tx_unit_on_out;
  logic line_break_event_in, rx_edge_event_in, nine_bit_out, send_break_out;
  logic [3:0] tx_break_bits_out, rx_break_bits_out;
  logic [7:0] exp_q[$];
  int mismatches = 0, cmp_count = 0, cyc = 0, last_t = 0, gap = 0, d;
  // Clock, device and far end of the line.
  always #5 ref_clk_in = ~ref_clk_in;
  serial_baud_rate_generator dut (.*, .avs_byteenable_in(4'h1));
  line_partner lp (.ref_clk_in, .tick_in(oversample_tick_out), .go_in(go),
    .edge_out(rx_edge_event_in), .brk_out(line_break_event_in));
  task automatic end_sim();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  // One bus access, held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, v};
    avs_write_in <= w;
    avs_read_in <= !w;
    @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge ref_clk_in);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic per(input int e);
    repeat (3 * e + 300) @(posedge ref_clk_in);
    chk("tick gap", 16'(e), 16'(gap));
  endtask
  task automatic irqx(input logic e);
    repeat (2) @(posedge ref_clk_in);
    chk("irq", {7'h0, e}, {7'h0, irq_out});
  endtask
  // Read answers meet the oldest note; tick spacing and the timeout are tracked.
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    if (avs_read_in && avs_waitrequest_out === 1'b0)
      chk("readdata", exp_q.pop_front(), avs_readdata_out[7:0]);
    if (oversample_tick_out === 1'b1)
    begin
      gap = cyc - last_t;
      last_t = cyc;
    end
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end
  // Main sequence.
  initial
  begin
    void'($urandom(40780));
    d = 2 + $urandom % 16;
    repeat (12) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    @(posedge ref_clk_in);
    rdx(4'h1, 8'h04);
    repeat (30) @(posedge ref_clk_in);
    chk("idle", 8'h00, 8'(last_t));
    bus(1'b1, 4'h2, 8'h0c);
    chk("units on", 16'h0003, {14'h0, tx_unit_on_out, rx_unit_on_out});
    per(4);
    bus(1'b1, 4'h1, 8'(d));
    per(d);
    bus(1'b1, 4'h0, 8'h01);
    per(d);
    rdx(4'h0, 8'h01);
    bus(1'b1, 4'h1, 8'h01);
    per(257);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h1, 8'h01);
    per(1);
    bus(1'b1, 4'h1, 8'h00);
    repeat (60) @(posedge ref_clk_in);
    chk("halt", 8'h01, 8'(cyc - last_t > 50));
    bus(1'b1, 4'h4, 8'h03);
    bus(1'b1, 4'h0, 8'h40);
    bus(1'b1, 4'h1, 8'(d));
    go <= 1'b1;
    repeat (180 * d + 40) @(posedge ref_clk_in);
    rdx(4'h3, 8'h03);
    irqx(1'b1);
    bus(1'b1, 4'h0, 8'h00);
    irqx(1'b0);
    bus(1'b1, 4'h0, 8'h80);
    irqx(1'b1);
    bus(1'b1, 4'h4, 8'h00);
    irqx(1'b0);
    go <= 1'b0;
    bus(1'b1, 4'h4, 8'h03);
    bus(1'b1, 4'h3, 8'h03);
    rdx(4'h3, 8'h00);
    irqx(1'b0);
    rdx(4'h9, 8'h00);
    bus(1'b1, 4'h5, 8'h03);
    chk("tx break", 8'h0d, {4'h0, tx_break_bits_out});
    chk("rx break", 8'h0b, {4'h0, rx_break_bits_out});
    chk("nine bit", 8'h01, {7'h0, nine_bit_out});
    bus(1'b1, 4'h2, 8'h0d);
    chk("send break", 8'h01, {7'h0, send_break_out});
    bus(1'b1, 4'h2, 8'h00);
    repeat (60) @(posedge ref_clk_in);
    chk("units off", 8'h01, 8'(cyc - last_t > 50));
    end_sim();
  end
endmodule // serial_baud_rate_generator_tb
`default_nettype wire
